// File: hw/ces_pkg.sv
// Purpose: Shared constants and carriers for the exception sequencer
// Assumes: 32-bit address and data, word-wide memory port
// Notes: Vector numbers and fixed table offsets live here
package ces_pkg;
  localparam int AW = 32;
  localparam logic [31:0] POR_PC_ADDR = 32'h00000000;
  localparam logic [31:0] POR_SP_ADDR = 32'h00000004;
  localparam logic [31:0] MAN_PC_ADDR = 32'h00000008;
  localparam logic [31:0] MAN_SP_ADDR = 32'h0000000C;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_SLOT = 8'h06;
  localparam logic [7:0] VEC_ADDR_ERR = 8'h09;
  localparam logic [7:0] VEC_TRAP_LO = 8'h20;
  localparam logic [7:0] VEC_TRAP_HI = 8'h3F;
  localparam logic [3:0] MASK_ALL = 4'hF;
  localparam int MASK_LSB = 4;
  localparam logic [31:0] STACK_STEP = 32'h00000004;
  localparam int VEC_SHIFT = 2;

  // Memory request towards the bus
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ces_mem_req_t;

  // Result handed back to the pipeline
  typedef struct packed {
    logic load_pc;
    logic [31:0] pc;
    logic load_sp;
    logic [31:0] sp;
    logic load_sr;
    logic [31:0] sr;
    logic load_vbr;
    logic [31:0] vector_base_reg;
  } ces_ctx_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WAIT = 4'h1,
    ST_RD_PC = 4'h2,
    ST_RD_SP = 4'h3,
    ST_INIT = 4'h4,
    ST_PUSH_SR = 4'h5,
    ST_PUSH_PC = 4'h6,
    ST_RD_VEC = 4'h7,
    ST_DONE = 4'h8
  } ces_state_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_POR = 3'h1,
    SRC_MAN = 3'h2,
    SRC_AERR = 3'h3,
    SRC_INT = 3'h4,
    SRC_TRAP = 3'h5,
    SRC_ILL = 3'h6,
    SRC_SLOT = 3'h7
  } ces_src_t;
endpackage

// File: hw/ces_sequencer.sv
// Purpose: Detect, rank and sequence CPU exceptions, then redirect the pipeline
// Assumes: Memory port answers each request with one i_mem_ack pulse
// Notes: Reset and interrupt pins arrive asynchronously and are triple-synchronised

// How it works
// - Exceptions pending together are serviced one at a time by fixed rank.
// - Reset pin rising with interrupt pin high starts a power-on reset.
// - Reset pin rising with interrupt pin low starts a manual reset.
// - Address errors and interrupts wait until the running instruction completes.
// - A trap starts when the trap instruction executes.
// - Undefined opcode outside a delay slot raises general illegal.
// - Undefined or PC-writing opcode in a delay slot raises illegal slot.
// - Power-on reset reads PC from 0 and SP from 4.
// - Manual reset reads PC from 8 and SP from C.
// - Reset then clears vector base and sets all four mask bits.
// - After reset, fetch resumes at the loaded PC.
// - Other exceptions push status word then PC through the stack register.
// - Accepted interrupt writes its level into the mask bits.
// - Address error and instruction exceptions keep the mask bits.
// - After stacking, the handler address is read and execution continues there.
// - Illegal uses vector 4, slot illegal 6, address error 9.
// - Trap vectors 32 to 63 come from the trap immediate.
// - Reset table address is vector number times four.
// - Other table addresses are vector base plus vector number times four.
// - Address error stacks the next instruction address; handler branch is not delayed.
module ces_sequencer
  import ces_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_reset_pin_n,
  input wire logic i_nmi_pin,
  input wire logic i_decode_valid,
  input wire logic i_in_delay_slot,
  input wire logic i_undefined_op,
  input wire logic i_pc_write_op,
  input wire logic i_trap_exec,
  input wire logic [7:0] i_trap_imm,
  input wire logic i_addr_err,
  input wire logic i_int_req,
  input wire logic [3:0] i_int_level,
  input wire logic [7:0] i_int_vector,
  input wire logic i_exec_done,
  input wire logic [31:0] i_next_pc,
  input wire logic [31:0] i_status_word,
  input wire logic [31:0] i_stack_pointer_gpr,
  input wire logic [31:0] i_vector_base_reg,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output ces_mem_req_t o_mem,
  output ces_ctx_t o_ctx,
  output logic o_busy,
  output logic o_int_ack
);

  ces_state_t state, next_state;
  ces_src_t src, next_src;
  logic [2:0] rst_sync, nmi_sync;
  logic por_pend, next_por_pend, man_pend, next_man_pend;
  logic aerr_pend, next_aerr_pend, int_pend, next_int_pend;
  logic [3:0] int_lvl, next_int_lvl;
  logic [7:0] int_vec, next_int_vec, vec, next_vec;
  logic [31:0] sp, next_sp, pc_save, next_pc_save;
  ces_mem_req_t next_mem;
  ces_ctx_t next_ctx;
  logic next_busy, next_int_ack;
  logic rst_rise, nmi_level, sync_exc;
  logic rst_low_seen, next_rst_low_seen;

  // Table address for a vector, with or without the base
  function automatic logic [31:0] vec_addr(input logic [7:0] v, input logic [31:0] base,
                                            input logic use_base);
    logic [31:0] off;
    off = {22'h000000, v, 2'h0};
    vec_addr = use_base ? base + off : off;
  endfunction

  // Pin synchronisers, three stages each
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rst_sync <= 3'h7;
      nmi_sync <= 3'h7;
      nmi_level <= 1'b1;
    end else begin
      rst_sync <= {rst_sync[1:0], i_reset_pin_n};
      nmi_sync <= {nmi_sync[1:0], i_nmi_pin};
      // Interrupt pin level only moves once stages two and three agree
      if (nmi_sync[1] == nmi_sync[2]) nmi_level <= nmi_sync[2];
    end
  end

  // Low-to-high once stages two and three agree on high after low
  assign rst_rise = rst_sync[1] && rst_sync[2] && !por_pend && !man_pend && rst_low_seen;
  // Synchronous exceptions from decode and execute
  assign sync_exc = i_trap_exec || (i_decode_valid && (i_undefined_op ||
                    (i_in_delay_slot && i_pc_write_op)));

  // Sequencer next-state logic
  always_comb begin
    next_state = state;
    next_src = src;
    next_por_pend = por_pend;
    next_man_pend = man_pend;
    next_aerr_pend = aerr_pend || i_addr_err;
    next_int_pend = int_pend;
    next_int_lvl = int_lvl;
    next_int_vec = int_vec;
    next_vec = vec;
    next_sp = sp;
    next_pc_save = pc_save;
    next_rst_low_seen = rst_low_seen;
    next_mem = '0;
    next_ctx = '0;
    next_busy = (state != ST_IDLE);
    next_int_ack = 1'b0;
    if (!rst_sync[1] && !rst_sync[2]) begin
      next_rst_low_seen = 1'b1;
    end
    if (rst_rise) begin
      next_rst_low_seen = 1'b0;
      next_por_pend = nmi_level;
      next_man_pend = !nmi_level;
    end
    if (i_int_req && i_decode_valid && !int_pend) begin
      next_int_pend = 1'b1;
      next_int_lvl = i_int_level;
      next_int_vec = i_int_vector;
    end
    case (state)
      ST_IDLE: begin
        // Fixed-rank arbitration; one source accepted at a time
        if (por_pend || man_pend) begin
          next_src = por_pend ? SRC_POR : SRC_MAN;
          next_state = ST_RD_PC;
          next_mem.valid = 1'b1;
          next_mem.addr = por_pend ? POR_PC_ADDR : MAN_PC_ADDR;
        end else if ((aerr_pend || i_addr_err) && i_exec_done) begin
          next_src = SRC_AERR;
          next_vec = VEC_ADDR_ERR;
          next_state = ST_WAIT;
        end else if (int_pend && i_exec_done) begin
          next_src = SRC_INT;
          next_vec = int_vec;
          next_int_ack = 1'b1;
          next_state = ST_WAIT;
        end else if (sync_exc) begin
          if (i_trap_exec) begin
            next_src = SRC_TRAP;
            next_vec = VEC_TRAP_LO | {2'h0, i_trap_imm[5:0]};
          end else if (i_in_delay_slot) begin
            next_src = SRC_SLOT;
            next_vec = VEC_SLOT;
          end else begin
            next_src = SRC_ILL;
            next_vec = VEC_ILLEGAL;
          end
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Capture stack and return PC, then push status word
        next_sp = i_stack_pointer_gpr - STACK_STEP;
        next_pc_save = i_next_pc;
        next_mem.valid = 1'b1;
        next_mem.write = 1'b1;
        next_mem.addr = i_stack_pointer_gpr - STACK_STEP;
        next_mem.wdata = i_status_word;
        next_state = ST_PUSH_SR;
      end
      ST_PUSH_SR: begin
        next_mem = o_mem;
        if (i_mem_ack) begin
          next_mem.addr = sp - STACK_STEP;
          next_mem.wdata = pc_save;
          next_sp = sp - STACK_STEP;
          next_state = ST_PUSH_PC;
        end
      end
      ST_PUSH_PC: begin
        next_mem = o_mem;
        if (i_mem_ack) begin
          next_mem = '0;
          next_mem.valid = 1'b1;
          next_mem.addr = vec_addr(vec, i_vector_base_reg, 1'b1);
          next_state = ST_RD_VEC;
        end
      end
      ST_RD_VEC: begin
        next_mem = o_mem;
        if (i_mem_ack) begin
          next_mem = '0;
          next_ctx.load_pc = 1'b1;
          next_ctx.pc = i_mem_rdata;
          next_ctx.load_sp = 1'b1;
          next_ctx.sp = sp;
          next_ctx.load_sr = 1'b1;
          next_ctx.sr = i_status_word;
          if (src == SRC_INT) begin
            next_ctx.sr[MASK_LSB +: 4] = int_lvl;
            next_int_pend = 1'b0;
          end
          // Mask bits pass through untouched otherwise
          if (src == SRC_AERR) next_aerr_pend = i_addr_err;
          next_state = ST_DONE;
        end
      end
      ST_RD_PC: begin
        next_mem = o_mem;
        if (i_mem_ack) begin
          next_pc_save = i_mem_rdata;
          next_mem.addr = (src == SRC_POR) ? POR_SP_ADDR : MAN_SP_ADDR;
          next_state = ST_RD_SP;
        end
      end
      ST_RD_SP: begin
        next_mem = o_mem;
        if (i_mem_ack) begin
          next_mem = '0;
          next_sp = i_mem_rdata;
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        // Reset context: base cleared, all mask bits set, start at loaded PC
        next_ctx.load_vbr = 1'b1;
        next_ctx.vector_base_reg = '0;
        next_ctx.load_sr = 1'b1;
        next_ctx.sr = i_status_word;
        next_ctx.sr[MASK_LSB +: 4] = MASK_ALL;
        next_ctx.load_pc = 1'b1;
        next_ctx.pc = pc_save;
        next_ctx.load_sp = 1'b1;
        next_ctx.sp = sp;
        next_por_pend = 1'b0;
        next_man_pend = 1'b0;
        next_aerr_pend = i_addr_err; // Set wins over the clear
        next_int_pend = 1'b0;
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_src = SRC_NONE;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      src <= SRC_NONE;
      por_pend <= 1'b0;
      man_pend <= 1'b0;
      aerr_pend <= 1'b0;
      int_pend <= 1'b0;
      int_lvl <= 4'h0;
      int_vec <= 8'h00;
      vec <= 8'h00;
      sp <= 32'h00000000;
      pc_save <= 32'h00000000;
      rst_low_seen <= 1'b0;
      o_mem <= '0;
      o_ctx <= '0;
      o_busy <= 1'b0;
      o_int_ack <= 1'b0;
    end else begin
      state <= next_state;
      src <= next_src;
      por_pend <= next_por_pend;
      man_pend <= next_man_pend;
      aerr_pend <= next_aerr_pend;
      int_pend <= next_int_pend;
      int_lvl <= next_int_lvl;
      int_vec <= next_int_vec;
      vec <= next_vec;
      sp <= next_sp;
      pc_save <= next_pc_save;
      rst_low_seen <= next_rst_low_seen;
      o_mem <= next_mem;
      o_ctx <= next_ctx;
      o_busy <= next_busy;
      o_int_ack <= next_int_ack;
    end
  end

  // Checks
  chk_reset_first: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_IDLE && (por_pend || man_pend)) |=> state == ST_RD_PC)
    else $error("reset not taken first");
  chk_por_pc_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_RD_PC && src == SRC_POR) |-> o_mem.addr == POR_PC_ADDR)
    else $error("power-on PC address wrong");
  chk_man_sp_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_RD_SP && src == SRC_MAN) |-> o_mem.addr == MAN_SP_ADDR)
    else $error("manual SP address wrong");
  chk_init_mask: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_INIT) |=> o_ctx.load_vbr && o_ctx.vector_base_reg == 32'h0 && o_ctx.sr[MASK_LSB +: 4] == MASK_ALL)
    else $error("reset init wrong");
  chk_reset_pc: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_INIT) |=> o_ctx.load_pc && o_ctx.pc == $past(pc_save))
    else $error("reset PC not loaded");
  chk_push_order: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_WAIT) |=> o_mem.write && o_mem.wdata == $past(i_status_word))
    else $error("status word not pushed first");
  chk_vec_addr: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_RD_VEC) |-> o_mem.addr == i_vector_base_reg + {22'h0, vec, 2'h0})
    else $error("vector address wrong");
  chk_addr_err_vec: assert property (@(posedge i_clk) disable iff (i_rst)
    (state != ST_IDLE && src == SRC_AERR && state != ST_DONE) |-> vec == VEC_ADDR_ERR)
    else $error("address error vector wrong");
  chk_trap_range: assert property (@(posedge i_clk) disable iff (i_rst)
    (src == SRC_TRAP && state != ST_DONE) |-> vec >= VEC_TRAP_LO && vec <= VEC_TRAP_HI)
    else $error("trap vector out of range");
  cov_por: cover property (@(posedge i_clk) state == ST_INIT && src == SRC_POR);
  cov_man: cover property (@(posedge i_clk) state == ST_INIT && src == SRC_MAN);
  cov_int: cover property (@(posedge i_clk) state == ST_RD_VEC && src == SRC_INT);
  cov_trap: cover property (@(posedge i_clk) state == ST_RD_VEC && src == SRC_TRAP);
endmodule

// File: verif/ces_mem_model.sv
// Purpose: Memory side facing the exception sequencer
// Assumes: One word per access, one ack pulse per request
// Notes: Read data is scrambled after each ack and while no request is valid; it is held during wait cycles
module ces_mem_model
  import ces_pkg::*;
(
  input wire logic i_clk,
  input wire ces_mem_req_t i_mem,
  input wire logic [1:0] i_wait,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:1023];
  logic [1:0] cnt;
  // Vector table and stack area set up before any exception
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'hC0000000 | (i << 4);
    end
    o_ack = 1'b0;
    o_rdata = 32'h0;
    cnt = 2'h0;
  end
  // Ack after i_wait idle cycles, never on two cycles in a row
  always @(posedge i_clk) begin
    if (o_ack || !i_mem.valid) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata; // Stale data never looks valid
      cnt <= 2'h0;
    end else if (cnt == i_wait) begin
      o_ack <= 1'b1;
      o_rdata <= mem[i_mem.addr[11:2]];
      if (i_mem.write) begin
        mem[i_mem.addr[11:2]] <= i_mem.wdata;
      end
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// File: verif/test_cpu_exception_sequencer.sv
// Purpose: Self-checking bench for the exception sequencer
// Assumes: Memory model answers with ack pulses, fast or slow
// Notes: Table rows first, then reset, hold-off and ranking cases
module test_cpu_exception_sequencer
  import ces_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    ces_src_t kind;
    logic pcw;
    logic [7:0] imm;
    logic [3:0] lvl;
    logic [7:0] vec;
  } ces_row_t;
  logic clk = 1'b0, rst = 1'b1, res_n = 1'b1, nmi = 1'b1, dv = 1'b0, slot = 1'b0;
  logic undef = 1'b0, pcw = 1'b0, trap = 1'b0, aerr = 1'b0, ireq = 1'b0, done = 1'b1;
  logic [7:0] imm = 8'h0, ivec = 8'h0;
  logic [3:0] lvl = 4'h0;
  logic [31:0] npc = 32'h00001234, sw = 32'h000000A1, sp = 32'h00000F00, vector_base_reg = 32'h00000400;
  logic [1:0] wait_n = 2'h0;
  ces_mem_req_t mreq;
  ces_ctx_t ctx, got;
  logic busy, iack, ack, saw_iack = 1'b0;
  logic [31:0] rdata;
  logic [32:0] acc_q [$];
  int fail_count = 0, num_checks = 0, ctx_n = 0;
  ces_row_t rows [8] = '{'{SRC_TRAP, 1'b0, 8'h20, 4'h0, 8'h20},
    '{SRC_TRAP, 1'b0, 8'h3F, 4'h0, 8'h3F}, '{SRC_ILL, 1'b0, 8'h0, 4'h0, 8'h04},
    '{SRC_SLOT, 1'b0, 8'h0, 4'h0, 8'h06}, '{SRC_SLOT, 1'b1, 8'h0, 4'h0, 8'h06},
    '{SRC_AERR, 1'b0, 8'h0, 4'h0, 8'h09}, '{SRC_INT, 1'b0, 8'h0, 4'h3, 8'h40},
    '{SRC_INT, 1'b0, 8'h0, 4'hF, 8'hFF}};

  always #2 clk = ~clk;

  ces_sequencer dut (.i_clk(clk), .i_rst(rst), .i_reset_pin_n(res_n), .i_nmi_pin(nmi),
    .i_decode_valid(dv), .i_in_delay_slot(slot), .i_undefined_op(undef),
    .i_pc_write_op(pcw), .i_trap_exec(trap), .i_trap_imm(imm), .i_addr_err(aerr),
    .i_int_req(ireq), .i_int_level(lvl), .i_int_vector(ivec), .i_exec_done(done),
    .i_next_pc(npc), .i_status_word(sw), .i_stack_pointer_gpr(sp),
    .i_vector_base_reg(vector_base_reg), .i_mem_ack(ack), .i_mem_rdata(rdata), .o_mem(mreq),
    .o_ctx(ctx), .o_busy(busy), .o_int_ack(iack));
  ces_mem_model mdl (.i_clk(clk), .i_mem(mreq), .i_wait(wait_n), .o_ack(ack),
    .o_rdata(rdata));

  // Log finished accesses, context pulses and interrupt acks
  always @(posedge clk) begin
    if (mreq.valid && ack) acc_q.push_back({mreq.write, mreq.addr});
    if (ctx.load_pc) begin
      got <= ctx;
      ctx_n <= ctx_n + 1;
    end
    if (iack) saw_iack <= 1'b1;
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Handler word held in the table at a given address
  function automatic logic [31:0] tbl(input logic [31:0] a);
    return 32'hC0000000 | {18'h0, a[11:2], 4'h0};
  endfunction

  // Wait for a context pulse, then for the sequencer to go idle
  task automatic wait_seq();
    int n0;
    n0 = ctx_n;
    for (int i = 0; i < 300 && ctx_n == n0; i++) @(negedge clk);
    if (ctx_n == n0) fail_count++; // No context pulse in time
    for (int i = 0; i < 20 && busy; i++) @(negedge clk);
    if (busy !== 1'b0) fail_count++; // Sequencer never went idle
  endtask

  task automatic hold_busy();
    for (int i = 0; i < 50 && busy !== 1'b1; i++) @(negedge clk);
    if (busy !== 1'b1) fail_count++; // Sequencer never started
  endtask

  task automatic drive(input ces_row_t r, input logic on);
    dv = on;
    trap = on && r.kind == SRC_TRAP;
    imm = r.imm;
    undef = on && (r.kind == SRC_ILL || (r.kind == SRC_SLOT && !r.pcw));
    slot = on && r.kind == SRC_SLOT;
    pcw = on && r.pcw;
    ireq = on && r.kind == SRC_INT;
    lvl = r.lvl;
    ivec = r.vec;
    aerr = on && r.kind == SRC_AERR;
  endtask

  // Stacking order, vector read and resulting context
  task automatic chk_exc(input logic [7:0] v, input logic is_int, input logic [3:0] l);
    logic [31:0] va;
    va = vector_base_reg + {22'h0, v, 2'h0};
    chk(acc_q.size(), 3);
    chk(acc_q[0], {1'b1, sp - 32'h4});
    chk(acc_q[1], {1'b1, sp - 32'h8});
    chk(acc_q[2], {1'b0, va});
    chk(mdl.mem[10'h3BF], sw);
    chk(mdl.mem[10'h3BE], npc);
    chk({got.load_pc, got.pc, got.sp}, {1'b1, tbl(va), sp - 32'h8});
    chk({got.load_sp, got.load_sr, got.load_vbr}, 3'b110);
    chk(got.sr, is_int ? {sw[31:8], l, sw[3:0]} : sw);
    chk(saw_iack, is_int);
    acc_q.delete();
    saw_iack = 1'b0;
    // Fresh stacked values so a missed push cannot pass on old memory
    npc = npc + 32'h2;
    sw = sw + 32'h1;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      wait_n = i[0] ? 2'h3 : 2'h0;
      drive(rows[i], 1'b1);
      @(negedge clk);
      aerr = 1'b0;
      hold_busy();
      drive(rows[i], 1'b0);
      wait_seq();
      chk_exc(rows[i].vec, rows[i].kind == SRC_INT, rows[i].lvl);
    end
    // Pin resets: power-on with interrupt pin high, manual with it low
    for (int k = 0; k < 2; k++) begin
      nmi = (k == 0);
      res_n = 1'b0;
      repeat (10) @(negedge clk);
      res_n = 1'b1;
      wait_seq();
      chk(acc_q[0], {1'b0, 28'h0, k[0], 3'h0});
      chk(acc_q[1], {1'b0, 28'h0, k[0], 3'h4});
      chk({got.load_pc, got.pc}, {1'b1, tbl({28'h0, k[0], 3'h0})});
      chk({got.load_sp, got.load_sr}, 2'b11);
      chk(got.sp, tbl({28'h0, k[0], 3'h4}));
      chk({got.load_vbr, got.vector_base_reg, got.sr[7:4]}, {1'b1, 32'h0, 4'hF});
      acc_q.delete();
    end
    nmi = 1'b1;
    // Address error waits for the running instruction
    done = 1'b0;
    aerr = 1'b1;
    @(negedge clk);
    aerr = 1'b0;
    repeat (10) @(negedge clk);
    chk({busy, mreq.valid}, 2'b00);
    done = 1'b1;
    wait_seq();
    chk_exc(8'h09, 1'b0, 4'h0);
    // Three sources together: address error, interrupt, trap
    wait_n = 2'h2;
    drive(ces_row_t'{SRC_INT, 1'b0, 8'h21, 4'h5, 8'h50}, 1'b1);
    trap = 1'b1;
    aerr = 1'b1;
    @(negedge clk);
    aerr = 1'b0;
    wait_seq();
    chk_exc(8'h09, 1'b0, 4'h0);
    hold_busy();
    ireq = 1'b0;
    wait_seq();
    chk_exc(8'h50, 1'b1, 4'h5);
    hold_busy();
    trap = 1'b0;
    wait_seq();
    chk_exc(8'h21, 1'b0, 4'h0);
    test_done();
  end
endmodule
